// file: slot_power_pkg.sv
// Shared constants, register map and carrier types for the two-slot power sequencer.
package slot_power_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Geometry.
  localparam int unsigned NUM_SLOTS  = 2;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned FILTER_W   = 16;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_FILTER     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_SLOT_STATE = 8'h10;

  // Slot state word: one byte lane per slot.
  localparam int unsigned SLOT_STATE_STRIDE = 8;
  // Interrupt bits: two per slot, main fault at the even position.
  localparam int unsigned IRQ_MAIN_POS = 0;
  localparam int unsigned IRQ_AUX_POS  = 1;
  localparam int unsigned IRQ_STRIDE   = 2;

  // Reset values.
  localparam logic [2*NUM_SLOTS-1:0] IRQ_STATUS_RST = 4'h0;
  localparam logic [2*NUM_SLOTS-1:0] IRQ_ENABLE_RST = 4'h0;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  //////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int unsigned CLK_PERIOD_NS        = 10;
  localparam int unsigned FAULT_FILTER_TIME_NS = 10000;
  localparam int unsigned FILTER_CYCLES_DEF    =
    (FAULT_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  //////////////////////////////////////////////////////////////////////////////
  // Carriers.
  typedef struct packed {
    logic main_enable;
    logic aux_enable;
    logic breaker_sense_5v;
    logic breaker_sense_3v3;
    logic pg_sense_3v3;
    logic pg_sense_5v;
    logic thermal_trip;
    logic input_uv;
    logic aux_overcurrent;
  } slot_pins_t;

  typedef struct packed {
    logic gate_drive_5v;
    logic gate_drive_3v3;
    logic gate_drive_12v;
    logic gate_drive_m12v;
    logic aux_rail_out;
  } slot_rails_t;

  typedef struct packed {
    logic fault;
    logic aux_latch;
    logic main_latch;
    logic pg_5v;
    logic pg_3v3;
    logic aux_on;
    logic main_on;
  } slot_stat_t;

endpackage : slot_power_pkg

// file: slot_power_ctrl.sv
// One slot: enable edge detection, breaker filter, fault latches and rail drives.
module slot_power_ctrl #(
  parameter int unsigned FW = 16
) (
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // Synchronised pins and settings
  input  slot_power_pkg::slot_pins_t     pins,
  input  wire logic                      standby_ok,
  input  wire logic [FW-1:0]             filter_cycles,
  // Rail drives and status
  output slot_power_pkg::slot_rails_t    rails,
  output logic                           fault_n,
  output slot_power_pkg::slot_stat_t     stat,
  output logic                           main_fault_evt,
  output logic                           aux_fault_evt
);
  import slot_power_pkg::*;

  typedef struct packed {
    logic          main_en_prev;
    logic          aux_en_prev;
    logic          main_on;
    logic          aux_on;
    logic          main_latch;
    logic          aux_latch;
    logic [FW-1:0] filt_cnt;
    logic          main_evt;
    logic          aux_evt;
  } slot_state_t;

  slot_state_t s_ff;
  slot_state_t nxt_s;
  logic        over;
  logic        trip;
  logic        main_flt;
  logic        aux_flt;

  always_comb begin
    nxt_s              = s_ff;
    nxt_s.main_en_prev = pins.main_enable;
    nxt_s.aux_en_prev  = pins.aux_enable;
    over               = pins.breaker_sense_5v | pins.breaker_sense_3v3;
    trip               = 1'b0;
    nxt_s.filt_cnt     = '0;
    if (s_ff.main_on && over) begin
      if (s_ff.filt_cnt >= filter_cycles - FW'(1)) begin
        trip = 1'b1;
      end else begin
        nxt_s.filt_cnt = s_ff.filt_cnt + FW'(1);
      end
    end
    main_flt = trip | pins.thermal_trip | (s_ff.main_on & pins.input_uv);
    aux_flt  = pins.thermal_trip | (s_ff.aux_on & pins.aux_overcurrent);
    // Clears come first so that a fault in the same cycle still lands.
    if (!pins.main_enable) begin
      nxt_s.main_latch = 1'b0;
    end
    if (!pins.aux_enable) begin
      nxt_s.aux_latch = 1'b0;
    end
    if (main_flt) begin
      nxt_s.main_latch = 1'b1;
    end
    if (aux_flt) begin
      nxt_s.aux_latch = 1'b1;
    end
    nxt_s.main_evt = main_flt & ~s_ff.main_latch;
    nxt_s.aux_evt  = aux_flt & ~s_ff.aux_latch;
    // Only a fresh edge powers up; a held-high enable after a fault does nothing.
    if (main_flt || !pins.main_enable) begin
      nxt_s.main_on = 1'b0;
    end else if (pins.main_enable && !s_ff.main_en_prev && !s_ff.main_latch
                 && !pins.input_uv) begin
      nxt_s.main_on = 1'b1;
    end
    if (aux_flt || !pins.aux_enable || !standby_ok) begin
      nxt_s.aux_on = 1'b0;
    end else if (pins.aux_enable && !s_ff.aux_en_prev && !s_ff.aux_latch) begin
      nxt_s.aux_on = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  always_comb begin
    rails.gate_drive_5v   = s_ff.main_on;
    rails.gate_drive_3v3  = s_ff.main_on;
    rails.gate_drive_12v  = s_ff.main_on;
    rails.gate_drive_m12v = s_ff.main_on;
    rails.aux_rail_out    = s_ff.aux_on;
    fault_n               = ~(s_ff.main_latch | s_ff.aux_latch);
    stat.fault            = s_ff.main_latch | s_ff.aux_latch;
    stat.aux_latch        = s_ff.aux_latch;
    stat.main_latch       = s_ff.main_latch;
    stat.pg_5v            = pins.pg_sense_5v;
    stat.pg_3v3           = pins.pg_sense_3v3;
    stat.aux_on           = s_ff.aux_on;
    stat.main_on          = s_ff.main_on;
    main_fault_evt        = s_ff.main_evt;
    aux_fault_evt         = s_ff.aux_evt;
  end

endmodule : slot_power_ctrl

// file: slot_power_enable_fault_latch.sv
// Two-slot power enable and fault latch top with AXI4-Lite registers and interrupt.
//
// Function
// - Aux rail turns on only on a rising aux enable edge, never on level.
// - Aux enable low clears the slot's aux fault latch.
// - Main enable rising edge turns on all four main rails; low turns them off.
// - Main enable low clears the slot's main fault latch.
// - Breaker sense high for the whole filter interval trips and drops the gates.
// - Overcurrent, thermal or undervoltage faults drop only the affected slot's gates.
// - Aux path stays off until standby supply is above its lockout level.
// - Registers and logic live on the standby supply, reachable with rails off.
// - 3.3V and 5V sense inputs give a readable power-good status.
// - Fault output is low while any latch is set; both enables must drop.
// - Interrupt low on any enabled fault; writing one to its bit clears it.
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
module slot_power_enable_fault_latch #(
  parameter int unsigned FILTER_CYCLES = slot_power_pkg::FILTER_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic                                 aclk,
  input  wire logic                                 aresetn,
  // AXI4-Lite write address
  input  wire logic                                 awvalid,
  output logic                                      awready,
  input  wire logic [slot_power_pkg::ADDR_W-1:0]    awaddr,
  input  wire logic [2:0]                           awprot,
  // AXI4-Lite write data
  input  wire logic                                 wvalid,
  output logic                                      wready,
  input  wire logic [slot_power_pkg::DATA_W-1:0]    wdata,
  input  wire logic [slot_power_pkg::DATA_W/8-1:0]  wstrb,
  // AXI4-Lite write response
  output logic                                      bvalid,
  input  wire logic                                 bready,
  output logic [1:0]                                bresp,
  // AXI4-Lite read address
  input  wire logic                                 arvalid,
  output logic                                      arready,
  input  wire logic [slot_power_pkg::ADDR_W-1:0]    araddr,
  input  wire logic [2:0]                           arprot,
  // AXI4-Lite read data
  output logic                                      rvalid,
  input  wire logic                                 rready,
  output logic [slot_power_pkg::DATA_W-1:0]         rdata,
  output logic [1:0]                                rresp,
  // Slot pins, asynchronous to aclk
  input  slot_power_pkg::slot_pins_t                slot_pins_a,
  input  slot_power_pkg::slot_pins_t                slot_pins_b,
  input  wire logic                                 standby_supply_ok,
  // Rail drives
  output slot_power_pkg::slot_rails_t               slot_rails_a,
  output slot_power_pkg::slot_rails_t               slot_rails_b,
  // Fault and interrupt, active low
  output logic                                      slot_fault_n_a,
  output logic                                      slot_fault_n_b,
  output logic                                      int_n
);
  import slot_power_pkg::*;

  localparam int unsigned NIRQ = 2 * NUM_SLOTS;

  if (FILTER_CYCLES < 1 || FILTER_CYCLES >= (1 << FILTER_W)) begin : g_bad_filter
    $error("FILTER_CYCLES must fit the filter counter and be at least one");
  end

  typedef struct packed {
    slot_pins_t [NUM_SLOTS-1:0] pin_meta;
    slot_pins_t [NUM_SLOTS-1:0] pin_sync;
    logic                       sby_meta;
    logic                       sby_sync;
    logic                       aw_held;
    logic [ADDR_W-1:0]          aw_addr;
    logic                       w_held;
    logic [DATA_W-1:0]          w_data;
    logic [DATA_W/8-1:0]        w_strb;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       rvalid;
    logic [DATA_W-1:0]          rdata;
    logic [1:0]                 rresp;
    logic [FILTER_W-1:0]        filter_cycles;
    logic [NIRQ-1:0]            irq_status;
    logic [NIRQ-1:0]            irq_enable;
  } top_state_t;

  top_state_t                 s_ff;
  top_state_t                 nxt_s;
  slot_rails_t [NUM_SLOTS-1:0] rails;
  slot_stat_t  [NUM_SLOTS-1:0] stat;
  logic        [NUM_SLOTS-1:0] fault_n_v;
  logic        [NIRQ-1:0]      evt;
  logic                       wr_fire;
  logic        [NIRQ-1:0]      irq_clr;
  logic        [DATA_W-1:0]    rd_word;
  logic                       rd_hit;
  logic        [DATA_W-1:0]    filt_word;
  logic        [DATA_W-1:0]    slot_word;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Word-aligned address match, shared by the read and write decoders.
  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [ADDR_W-1:0] ofs);
    hit = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction : hit

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    is_mapped = hit(addr, OFS_FILTER) | hit(addr, OFS_IRQ_STATUS) | hit(addr, OFS_IRQ_CLEAR)
              | hit(addr, OFS_IRQ_ENABLE) | hit(addr, OFS_SLOT_STATE);
  endfunction : is_mapped

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0]   old,
                                              input logic [DATA_W-1:0]   data,
                                              input logic [DATA_W/8-1:0] strb);
    merge = old;
    for (int b = 0; b < DATA_W / 8; b++) begin
      if (strb[b]) begin
        merge[8*b +: 8] = data[8*b +: 8];
      end
    end
  endfunction : merge

  //////////////////////////////////////////////////////////////////////////////
  // Slots.

  for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
    slot_power_ctrl #(
      .FW (FILTER_W)
    ) u_slot (
      .aclk           (aclk),
      .aresetn        (aresetn),
      .pins           (s_ff.pin_sync[i]),
      .standby_ok     (s_ff.sby_sync),
      .filter_cycles  (s_ff.filter_cycles),
      .rails          (rails[i]),
      .fault_n        (fault_n_v[i]),
      .stat           (stat[i]),
      .main_fault_evt (evt[IRQ_STRIDE*i+IRQ_MAIN_POS]),
      .aux_fault_evt  (evt[IRQ_STRIDE*i+IRQ_AUX_POS])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    nxt_s          = s_ff;
    // Pins are asynchronous; the first stage feeds only the second.
    nxt_s.pin_meta = {slot_pins_b, slot_pins_a};
    nxt_s.pin_sync = s_ff.pin_meta;
    nxt_s.sby_meta = standby_supply_ok;
    nxt_s.sby_sync = s_ff.sby_meta;

    // Write channel: address and data are taken in either order.
    if (awvalid && !s_ff.aw_held) begin
      nxt_s.aw_held = 1'b1;
      nxt_s.aw_addr = awaddr;
    end
    if (wvalid && !s_ff.w_held) begin
      nxt_s.w_held = 1'b1;
      nxt_s.w_data = wdata;
      nxt_s.w_strb = wstrb;
    end
    if (s_ff.bvalid && bready) begin
      nxt_s.bvalid = 1'b0;
    end
    wr_fire   = s_ff.aw_held && s_ff.w_held && !s_ff.bvalid;
    irq_clr   = '0;
    filt_word = merge(DATA_W'(s_ff.filter_cycles), s_ff.w_data, s_ff.w_strb);
    if (wr_fire) begin
      nxt_s.aw_held = 1'b0;
      nxt_s.w_held  = 1'b0;
      nxt_s.bvalid  = 1'b1;
      nxt_s.bresp   = is_mapped(s_ff.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (hit(s_ff.aw_addr, OFS_FILTER)) begin
        // A zero interval would wrap the compare and trip only after 65536 overcurrent cycles; keep one.
        nxt_s.filter_cycles = (filt_word[FILTER_W-1:0] == '0) ? FILTER_W'(1)
                                                              : filt_word[FILTER_W-1:0];
      end
      if (hit(s_ff.aw_addr, OFS_IRQ_STATUS) || hit(s_ff.aw_addr, OFS_IRQ_CLEAR)) begin
        irq_clr = s_ff.w_strb[0] ? s_ff.w_data[NIRQ-1:0] : '0;
      end
      if (hit(s_ff.aw_addr, OFS_IRQ_ENABLE) && s_ff.w_strb[0]) begin
        nxt_s.irq_enable = s_ff.w_data[NIRQ-1:0];
      end
    end

    // A fault landing in the clearing cycle stays set.
    nxt_s.irq_status = (s_ff.irq_status & ~irq_clr) | evt;

    // Read channel.
    slot_word = '0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      slot_word[SLOT_STATE_STRIDE*i +: $bits(slot_stat_t)] = stat[i];
    end
    rd_hit  = 1'b1;
    rd_word = '0;
    if (hit(araddr, OFS_FILTER)) begin
      rd_word = DATA_W'(s_ff.filter_cycles);
    end else if (hit(araddr, OFS_IRQ_STATUS)) begin
      rd_word = DATA_W'(s_ff.irq_status);
    end else if (hit(araddr, OFS_IRQ_ENABLE)) begin
      rd_word = DATA_W'(s_ff.irq_enable);
    end else if (hit(araddr, OFS_SLOT_STATE)) begin
      rd_word = slot_word;
    end else if (!hit(araddr, OFS_IRQ_CLEAR)) begin
      rd_hit = 1'b0;
    end
    if (s_ff.rvalid && rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (arvalid && !s_ff.rvalid) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata  = rd_word;
      nxt_s.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.

  // The reset is expected from the standby supply's power-on detector, so the
  // register file survives while the main rails are down.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff               <= '0;
      s_ff.filter_cycles <= FILTER_W'(FILTER_CYCLES);
      s_ff.irq_status    <= IRQ_STATUS_RST;
      s_ff.irq_enable    <= IRQ_ENABLE_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign awready        = ~s_ff.aw_held;
  assign wready         = ~s_ff.w_held;
  assign bvalid         = s_ff.bvalid;
  assign bresp          = s_ff.bresp;
  assign arready        = ~s_ff.rvalid;
  assign rvalid         = s_ff.rvalid;
  assign rdata          = s_ff.rdata;
  assign rresp          = s_ff.rresp;
  assign slot_rails_a   = rails[0];
  assign slot_rails_b   = rails[1];
  assign slot_fault_n_a = fault_n_v[0];
  assign slot_fault_n_b = fault_n_v[1];
  assign int_n          = ~|(s_ff.irq_status & s_ff.irq_enable);

  //////////////////////////////////////////////////////////////////////////////
  // Checks. Slot A is watched through its synchronised pins and its outputs.

  logic pa_main_en;
  logic pa_aux_en;
  logic pa_over;
  assign pa_main_en = s_ff.pin_sync[0].main_enable;
  assign pa_aux_en  = s_ff.pin_sync[0].aux_enable;
  assign pa_over    = s_ff.pin_sync[0].breaker_sense_5v | s_ff.pin_sync[0].breaker_sense_3v3;

  property p_aux_on_edge;
    @(posedge aclk) disable iff (!aresetn)
      $rose(slot_rails_a.aux_rail_out) |-> $past(pa_aux_en) && !$past(pa_aux_en, 2);
  endproperty
  a_aux_on_edge: assert property (p_aux_on_edge) else $error("aux rail rose without edge");

  property p_aux_latch_clear;
    @(posedge aclk) disable iff (!aresetn)
      stat[0].aux_latch && !pa_aux_en && !s_ff.pin_sync[0].thermal_trip
      |=> !stat[0].aux_latch;
  endproperty
  a_aux_latch_clear: assert property (p_aux_latch_clear) else $error("aux latch not cleared");

  property p_main_on_edge;
    @(posedge aclk) disable iff (!aresetn)
      $rose(slot_rails_a.gate_drive_5v) |-> $past(pa_main_en) && !$past(pa_main_en, 2)
      && slot_rails_a.gate_drive_3v3 && slot_rails_a.gate_drive_12v
      && slot_rails_a.gate_drive_m12v;
  endproperty
  a_main_on_edge: assert property (p_main_on_edge) else $error("main rails rose badly");

  property p_main_off;
    @(posedge aclk) disable iff (!aresetn)
      !pa_main_en |=> !slot_rails_a.gate_drive_5v && !slot_rails_a.gate_drive_m12v;
  endproperty
  a_main_off: assert property (p_main_off) else $error("main rails stayed on");

  property p_main_latch_clear;
    @(posedge aclk) disable iff (!aresetn)
      stat[0].main_latch && !pa_main_en && !s_ff.pin_sync[0].thermal_trip
      |=> !stat[0].main_latch;
  endproperty
  a_main_latch_clear: assert property (p_main_latch_clear) else $error("main latch kept");

  property p_breaker_trip;
    @(posedge aclk) disable iff (!aresetn)
      (s_ff.filter_cycles == FILTER_W'(2)) && slot_rails_a.gate_drive_5v && pa_over && pa_main_en
      ##1 pa_over && pa_main_en |=> !slot_rails_a.gate_drive_5v && stat[0].main_latch;
  endproperty
  a_breaker_trip: assert property (p_breaker_trip) else $error("breaker did not trip");

  property p_breaker_hold;
    @(posedge aclk) disable iff (!aresetn)
      (s_ff.filter_cycles > FILTER_W'(1)) && slot_rails_a.gate_drive_5v && pa_over && pa_main_en
      && !$past(pa_over) && !s_ff.pin_sync[0].thermal_trip && !s_ff.pin_sync[0].input_uv
      |=> slot_rails_a.gate_drive_5v;
  endproperty
  a_breaker_hold: assert property (p_breaker_hold) else $error("breaker tripped early");

  property p_thermal_isolated;
    @(posedge aclk) disable iff (!aresetn)
      s_ff.pin_sync[0].thermal_trip && !s_ff.pin_sync[1].thermal_trip
      && slot_rails_b.gate_drive_5v && s_ff.pin_sync[1].main_enable
      && !s_ff.pin_sync[1].input_uv && !(s_ff.pin_sync[1].breaker_sense_5v
      | s_ff.pin_sync[1].breaker_sense_3v3)
      |=> !slot_rails_a.gate_drive_5v && !slot_rails_a.aux_rail_out && slot_rails_b.gate_drive_5v;
  endproperty
  a_thermal_isolated: assert property (p_thermal_isolated) else $error("fault not isolated");

  property p_standby_lockout;
    @(posedge aclk) disable iff (!aresetn)
      !s_ff.sby_sync |=> !slot_rails_a.aux_rail_out && !slot_rails_b.aux_rail_out;
  endproperty
  a_standby_lockout: assert property (p_standby_lockout) else $error("aux on in lockout");

  property p_fault_both;
    @(posedge aclk) disable iff (!aresetn)
      stat[0].main_latch && stat[0].aux_latch && !pa_main_en && pa_aux_en
      |=> !slot_fault_n_a;
  endproperty
  a_fault_both: assert property (p_fault_both) else $error("fault released early");

  property p_irq_raise;
    @(posedge aclk) disable iff (!aresetn)
      |(evt & s_ff.irq_enable) |=> !int_n;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("interrupt not raised");

  property p_irq_clear;
    @(posedge aclk) disable iff (!aresetn)
      wr_fire && hit(s_ff.aw_addr, OFS_IRQ_CLEAR) && s_ff.w_strb[0]
      && s_ff.w_data[IRQ_MAIN_POS] && !evt[IRQ_MAIN_POS] |=> !s_ff.irq_status[IRQ_MAIN_POS];
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("status bit not cleared");

  property p_latch_holds_off;
    @(posedge aclk) disable iff (!aresetn)
      stat[0].main_latch |=> !$rose(slot_rails_a.gate_drive_5v);
  endproperty
  a_latch_holds_off: assert property (p_latch_holds_off) else $error("rails on with latch");

endmodule : slot_power_enable_fault_latch

// file: slot_host_model.sv
// Host controller model that drives one slot's enable pins.
module slot_host_model (
  // Clock
  input  wire logic aclk,
  // Requests
  input  wire logic serial_mode,
  input  wire logic main_req,
  input  wire logic aux_req,
  // Enable pins
  output logic      main_en,
  output logic      aux_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // Under serial-bus control the pins stay low, so no stray edge can power a slot.
  always_ff @(posedge aclk) begin
    main_en <= main_req & ~serial_mode;
    aux_en  <= aux_req & ~serial_mode;
  end
endmodule : slot_host_model

// file: slot_power_enable_fault_latch_test.sv
// Self-checking bench for the two-slot power enable and fault latch block.
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module slot_power_enable_fault_latch_test;
  timeunit 1ns;
  timeprecision 1ps;
  import slot_power_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic standby_supply_ok = 1, srl = 0, mreq = 0, areq = 0, m_en, a_en;
  logic awready, wready, bvalid, arready, rvalid, int_n, slot_fault_n_a, slot_fault_n_b;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  slot_pins_t pa = '0, pb = '0, slot_pins_a;
  slot_rails_t slot_rails_a, slot_rails_b;
  int n_fail = 0, checks_done = 0;
  always #5 aclk = ~aclk;
  always_comb begin
    slot_pins_a = pa;
    slot_pins_a.main_enable = m_en;
    slot_pins_a.aux_enable = a_en;
  end
  slot_host_model u_host (.aclk, .serial_mode(srl), .main_req(mreq), .aux_req(areq),
    .main_en(m_en), .aux_en(a_en));
  slot_power_enable_fault_latch #(.FILTER_CYCLES(4)) u_dut (.aclk, .aresetn, .awvalid,
    .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid,
    .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata,
    .rresp, .slot_pins_a, .slot_pins_b(pb), .standby_supply_ok, .slot_rails_a,
    .slot_rails_b, .slot_fault_n_a, .slot_fault_n_b, .int_n);
  //////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask : cyc
  // Ready is looked at mid-cycle, so the edge that follows is the one that takes the item.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta = 0, tw = 0;
    @(posedge aclk);
    {awvalid, wvalid, bready, awaddr, wdata} <= {3'h7, a, d};
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta |= awready;
      tw |= wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1) @(negedge aclk);
    rs = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    {arvalid, rready, araddr} <= {2'h3, a};
    @(negedge aclk);
    while (arready !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    arvalid <= 1'b0;
    @(negedge aclk);
    while (rvalid !== 1'b1) @(negedge aclk);
    {rs, rd} = {rresp, rdata};
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd_reg
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_power_on;
    @(posedge aclk);
    mreq <= 1'b1;
    pb.main_enable <= 1'b1;
    pa.pg_sense_3v3 <= 1'b1;
    cyc(6);
    `CHK("gates a", 4'hf, slot_rails_a[4:1])
    `CHK("gates b", 4'hf, slot_rails_b[4:1])
    rd_reg(OFS_SLOT_STATE);
    `CHK("slot state", 32'h0000_0105, rd)
  endtask : t_power_on
  task automatic t_aux;
    @(posedge aclk);
    standby_supply_ok <= 1'b0;
    areq <= 1'b1;
    cyc(6);
    `CHK("aux lockout", 1'b0, slot_rails_a.aux_rail_out)
    @(posedge aclk);
    standby_supply_ok <= 1'b1;
    cyc(6);
    `CHK("aux level", 1'b0, slot_rails_a.aux_rail_out)
    @(posedge aclk);
    areq <= 1'b0;
    cyc(4);
    @(posedge aclk);
    areq <= 1'b1;
    cyc(6);
    `CHK("aux edge", 1'b1, slot_rails_a.aux_rail_out)
  endtask : t_aux
  task automatic t_breaker;
    wr(OFS_IRQ_ENABLE, 32'h1);
    wr(OFS_FILTER, 32'h2);
    rd_reg(OFS_FILTER);
    `CHK("filter", 32'h2, rd)
    @(posedge aclk);
    pa.breaker_sense_5v <= 1'b1;
    cyc(3);
    `CHK("filtering", 4'hf, slot_rails_a[4:1])
    cyc(11);
    `CHK("trip gates", 4'h0, slot_rails_a[4:1])
    `CHK("fault a", 1'b0, slot_fault_n_a)
    `CHK("irq", 1'b0, int_n)
    `CHK("gates b", 4'hf, slot_rails_b[4:1])
    @(posedge aclk);
    pa.breaker_sense_5v <= 1'b0;
    wr(OFS_IRQ_CLEAR, 32'h1);
    cyc(2);
    `CHK("irq clr", 1'b1, int_n)
    `CHK("held off", 4'h0, slot_rails_a[4:1])
    @(posedge aclk);
    mreq <= 1'b0;
    cyc(6);
    `CHK("fault a", 1'b1, slot_fault_n_a)
    @(posedge aclk);
    mreq <= 1'b1;
    cyc(6);
    `CHK("rearm", 4'hf, slot_rails_a[4:1])
  endtask : t_breaker
  task automatic t_thermal;
    @(posedge aclk);
    pa.thermal_trip <= 1'b1;
    cyc(6);
    @(posedge aclk);
    pa.thermal_trip <= 1'b0;
    mreq <= 1'b0;
    cyc(6);
    `CHK("rails a", 5'h00, slot_rails_a)
    `CHK("gates b", 4'hf, slot_rails_b[4:1])
    `CHK("fault a", 1'b0, slot_fault_n_a)
    rd_reg(OFS_SLOT_STATE);
    `CHK("latches", 2'b10, rd[5:4])
    @(posedge aclk);
    areq <= 1'b0;
    pb.input_uv <= 1'b1;
    cyc(6);
    `CHK("fault a", 1'b1, slot_fault_n_a)
    `CHK("uv b", 5'h00, slot_rails_b)
    `CHK("fault b", 1'b0, slot_fault_n_b)
  endtask : t_thermal
  task automatic t_regs;
    `CHK("irq", 1'b0, int_n)
    wr(OFS_IRQ_ENABLE, 32'h0);
    cyc(1);
    `CHK("masked", 1'b1, int_n)
    rd_reg(OFS_IRQ_STATUS);
    `CHK("status", 32'h7, rd)
    wr(OFS_IRQ_CLEAR, 32'hf);
    rd_reg(OFS_IRQ_STATUS);
    `CHK("cleared", 32'h0, rd)
    rd_reg(8'h40);
    `CHK("bad rd", {RESP_SLVERR, 32'h0}, {rs, rd})
    wr(8'h40, 32'h1);
    `CHK("bad wr", RESP_SLVERR, rs)
    @(posedge aclk);
    srl <= 1'b1;
    mreq <= 1'b1;
    cyc(6);
    `CHK("serial", 4'h0, slot_rails_a[4:1])
  endtask : t_regs
  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_power_on();
    t_aux();
    t_breaker();
    t_thermal();
    t_regs();
    conclude();
  end
  // The whole run needs under two hundred cycles; this limit of 2000 cycles leaves a wide margin.
  initial begin
    #20us;
    n_fail++;
    conclude();
  end
endmodule : slot_power_enable_fault_latch_test
